// ===== logic/pit_pkg.sv
// Shared constants, types and helpers of the three-counter interval timer.
package pit_pkg;

    // Bus address that selects the control word location.
    localparam logic [1:0] ADDR_CTRL = 2'h3;

    // Control word field positions.
    localparam int CW_SEL_LSB  = 6;
    localparam int CW_FMT_LSB  = 4;
    localparam int CW_MODE_LSB = 1;
    localparam int CW_BCD_BIT  = 0;

    // Counter-select code that marks a read-back command.
    localparam logic [1:0] SEL_READBACK = 2'h3;

    // Read-back command fields: count latch, status latch, counter picks.
    localparam int RB_CNT_BIT = 5;
    localparam int RB_ST_BIT  = 4;
    localparam int RB_PICK_LSB = 1;

    // Reset values of each counter's programming.
    localparam logic [2:0]  RST_MODE = 3'h0;
    localparam logic [15:0] RST_COUNT = 16'h0000;

    // Count element values that mark the end of a period.
    localparam logic [15:0] CE_ONE = 16'h0001;
    localparam logic [15:0] CE_TWO = 16'h0002;

    // Access format of count reads and writes.
    typedef enum logic [1:0] {
        PIT_FMT_LATCH = 2'b00,
        PIT_FMT_LSB   = 2'b01,
        PIT_FMT_MSB   = 2'b10,
        PIT_FMT_BOTH  = 2'b11
    } pit_fmt_t;

    // Decrement by one, wrapping zero to all ones or to all nines.
    function automatic logic [15:0] pit_dec(input logic [15:0] v,
                                            input logic        bcd);
        logic [15:0] r;
        logic        borrow;
        r      = v - 16'h0001;
        borrow = 1'b1;
        if (bcd) begin
            r = v;
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (r[4*d +: 4] == 4'h0) begin
                        r[4*d +: 4] = 4'h9;
                    end else begin
                        r[4*d +: 4] = r[4*d +: 4] - 4'h1;
                        borrow      = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

endpackage

// ===== logic/pit_timer.sv
// Three-counter programmable interval timer: programming, readout, modes.
//
// Behaviour
// [RULE1] Mode 1: gate rising edge starts counting, output low after next clock.
// [RULE2] Modes 2 and 3: gate low stops counting, output high at once.
// [RULE3] With status and count latched, first read gives status, then count.
// [RULE4] Host writes a control word first, then count in chosen format.
// [RULE5] Each counter keeps its own control word; any programming order.
// [RULE6] New count may be written without a new control word.
// [RULE7] Host must not write control between two bytes of a count.
// [RULE8] Unlatched read returns the live, possibly changing, count.
// [RULE9] Latch command holds the count until read or reprogrammed.
// [RULE10] Repeated latch commands before a read keep the first value.
// [RULE11] Host reads a two-byte latched count with two consecutive reads.
// [RULE12] Read-back latches count and/or status of every picked counter.
// [RULE13] Status holds control bits D0-D5 and output level in D7.
// [RULE14] Load-pending D6 sets on control or count write, clears on load.
// [RULE15] Mode 0: control word drives output low until count hits zero.
// [RULE16] Mode 0: count loads on next clock without decrement; N+1 pulses.
// [RULE17] Mode 0: first byte halts and lowers output; second lets it load.
// [RULE18] Mode 0: count written with gate low still loads on next clock.
// [RULE19] Mode 1: output idles high; each trigger gives N-pulse low output.
// [RULE20] Mode 1: new count affects only the next retrigger.
// [RULE21] Mode 2: output low one clock at count 1, then reload.
// [RULE22] Count element is a 16-bit down counter loaded whole.
// [RULE23] Both count register bytes clear when the counter is programmed.
// [RULE24] Modes 0, 1, 4, 5 wrap zero to all ones or all nines.
// [RULE25] The three counters run independently with their own state.
`timescale 1ns/1ps

module pit_timer #(
    parameter int NUM_CNT = 3
) (
    input  wire logic               CLOCK,
    input  wire logic               RST_N,
    input  wire logic [1:0]         ADDR,
    input  wire logic [7:0]         WDATA,
    input  wire logic               WR_STB,
    input  wire logic               RD_STB,
    output logic      [7:0]         RDATA,
    input  wire logic [NUM_CNT-1:0] CNT_CLK,
    input  wire logic [NUM_CNT-1:0] CNT_GATE,
    output logic      [NUM_CNT-1:0] CNT_OUT
);

    // Byte each counter would put on the bus if read now.
    logic [7:0] rd_byte [NUM_CNT];

    // Fields of the byte on the write bus, shared by all counters.
    logic [1:0] w_sel;
    logic [1:0] w_fmt;
    logic       cw_wr;
    logic       rb_cmd;
    assign w_sel  = WDATA[pit_pkg::CW_SEL_LSB +: 2];
    assign w_fmt  = WDATA[pit_pkg::CW_FMT_LSB +: 2];
    assign cw_wr  = WR_STB && (ADDR == pit_pkg::ADDR_CTRL);
    assign rb_cmd = cw_wr && (w_sel == pit_pkg::SEL_READBACK);

    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        // Per-counter state; nothing here is shared between counters.
        logic [2:0]        clk_sy_ff;
        logic [2:0]        gate_sy_ff;
        logic [2:0]        mode_ff; // [RULE25]
        pit_pkg::pit_fmt_t fmt_ff;
        logic              bcd_ff;
        logic [15:0]       cr_ff;
        logic [15:0]       ce_ff;
        logic [15:0]       ol_ff;
        logic [7:0]        st_ff;
        logic              ol_held_ff;
        logic              st_held_ff;
        logic              wr_hi_ff;
        logic              rd_hi_ff;
        logic              null_ff;
        logic              out_ff;
        logic              load_ff;
        logic              run_ff;
        logic              trig_ff;
        logic              pulse;
        logic              gate;
        logic              tseen;
        logic              my_cw;
        logic              cnt_wr;
        logic              cnt_done;
        logic              lat_cnt;
        logic              lat_st;
        logic              rd_hit;
        logic              m04;
        logic              m15;
        logic              m23;
        logic [7:0]        status;
        logic [15:0]       src;

        // Pin inputs pass two flops; the third flop only feeds edge logic.
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                clk_sy_ff  <= 3'h0;
                gate_sy_ff <= 3'h0;
            end else begin
                clk_sy_ff  <= {clk_sy_ff[1:0], CNT_CLK[i]};
                gate_sy_ff <= {gate_sy_ff[1:0], CNT_GATE[i]};
            end
        end

        // A count clock pulse is taken at its rising edge.
        assign pulse = clk_sy_ff[1] && !clk_sy_ff[2];
        assign gate  = gate_sy_ff[1];
        assign tseen = trig_ff || (gate_sy_ff[1] && !gate_sy_ff[2]);

        // Gate trigger flop: set by a rising edge, consumed by a pulse.
        // A trigger coinciding with a pulse is used by that pulse.
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                trig_ff <= 1'b0;
            end else begin
                trig_ff <= tseen && !pulse;
            end
        end

        // Mode classes; codes 6 and 7 behave as 2 and 3.
        assign m04 = !mode_ff[1] && !mode_ff[0];
        assign m15 = !mode_ff[1] && mode_ff[0];
        assign m23 = mode_ff[1];

        // Bus decode for this counter.
        assign my_cw    = cw_wr && (w_sel == 2'(i)) &&
                          (w_fmt != pit_pkg::PIT_FMT_LATCH);
        assign cnt_wr   = WR_STB && (ADDR == 2'(i));
        assign cnt_done = cnt_wr &&
                          ((fmt_ff != pit_pkg::PIT_FMT_BOTH) || wr_hi_ff);
        assign lat_cnt  = (cw_wr && (w_sel == 2'(i)) &&
                           (w_fmt == pit_pkg::PIT_FMT_LATCH)) ||
                          (rb_cmd && WDATA[pit_pkg::RB_PICK_LSB + i] &&
                           WDATA[pit_pkg::RB_CNT_BIT]); // [RULE9] [RULE12]
        assign lat_st   = rb_cmd && WDATA[pit_pkg::RB_PICK_LSB + i] &&
                          WDATA[pit_pkg::RB_ST_BIT]; // [RULE12]
        assign rd_hit   = RD_STB && (ADDR == 2'(i));

        // Status byte: output level, load pending, then control bits.
        assign status = {out_ff, null_ff, fmt_ff, mode_ff, bcd_ff}; // [RULE13]

        // Programming, count element, output and load-pending flag.
        // Bus writes are applied after the pulse actions so that a write
        // landing on a load keeps its pending flag set.
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                mode_ff  <= pit_pkg::RST_MODE;
                fmt_ff   <= pit_pkg::PIT_FMT_LSB;
                bcd_ff   <= 1'b0;
                cr_ff    <= pit_pkg::RST_COUNT;
                ce_ff    <= pit_pkg::RST_COUNT;
                wr_hi_ff <= 1'b0;
                null_ff  <= 1'b0;
                out_ff   <= 1'b0;
                load_ff  <= 1'b0;
                run_ff   <= 1'b0;
            end else if (my_cw) begin
                // Control word resets this counter's logic only. [RULE5]
                mode_ff  <= WDATA[pit_pkg::CW_MODE_LSB +: 3];
                fmt_ff   <= pit_pkg::pit_fmt_t'(w_fmt);
                bcd_ff   <= WDATA[pit_pkg::CW_BCD_BIT];
                cr_ff    <= pit_pkg::RST_COUNT; // [RULE23]
                wr_hi_ff <= 1'b0;
                null_ff  <= 1'b1; // [RULE14]
                load_ff  <= 1'b0;
                run_ff   <= 1'b0;
                // Mode 0 starts low, every other mode idles high.
                out_ff   <= (WDATA[pit_pkg::CW_MODE_LSB +: 3] != 3'h0); // [RULE15] [RULE19]
            end else begin
                if (m23 && !gate) begin
                    out_ff <= 1'b1; // [RULE2]
                end
                if (pulse) begin
                    if (m04) begin
                        if (load_ff) begin
                            ce_ff   <= cr_ff; // [RULE16] [RULE18] [RULE22]
                            null_ff <= 1'b0; // [RULE14]
                            load_ff <= 1'b0;
                            run_ff  <= 1'b1;
                        end else if (run_ff && gate) begin
                            ce_ff <= pit_pkg::pit_dec(ce_ff, bcd_ff); // [RULE24]
                            if (ce_ff == pit_pkg::CE_ONE && !mode_ff[2]) begin
                                out_ff <= 1'b1; // [RULE15]
                            end
                        end
                    end else if (m15) begin
                        if (tseen && load_ff) begin
                            // Retrigger takes the latest count. [RULE20]
                            ce_ff   <= cr_ff;
                            null_ff <= 1'b0;
                            run_ff  <= 1'b1;
                            out_ff  <= mode_ff[2]; // [RULE1] [RULE19]
                        end else if (run_ff) begin
                            ce_ff <= pit_pkg::pit_dec(ce_ff, bcd_ff); // [RULE24]
                            if (ce_ff == pit_pkg::CE_ONE) begin
                                out_ff <= 1'b1; // [RULE19]
                            end
                        end
                    end else begin
                        if ((load_ff && !run_ff) || (tseen && gate && load_ff)) begin
                            ce_ff   <= cr_ff; // [RULE2]
                            null_ff <= 1'b0;
                            run_ff  <= 1'b1;
                            out_ff  <= 1'b1;
                        end else if (run_ff && gate) begin
                            if (ce_ff == pit_pkg::CE_TWO) begin
                                ce_ff  <= pit_pkg::CE_ONE;
                                out_ff <= 1'b0; // [RULE21]
                            end else if (ce_ff == pit_pkg::CE_ONE) begin
                                ce_ff   <= cr_ff; // [RULE21]
                                null_ff <= 1'b0;
                                out_ff  <= 1'b1;
                            end else begin
                                ce_ff <= ce_ff - 16'h0001;
                            end
                        end
                    end
                end
                if (cnt_wr) begin
                    // Bytes go where the stored format says. [RULE6]
                    unique case (fmt_ff)
                        pit_pkg::PIT_FMT_MSB: begin
                            cr_ff[15:8] <= WDATA;
                        end
                        pit_pkg::PIT_FMT_BOTH: begin
                            wr_hi_ff <= !wr_hi_ff;
                            if (wr_hi_ff) begin
                                cr_ff[15:8] <= WDATA;
                            end else begin
                                cr_ff[7:0] <= WDATA;
                                if (m04 && !mode_ff[2]) begin
                                    run_ff <= 1'b0; // [RULE17]
                                    out_ff <= 1'b0; // [RULE17]
                                end
                            end
                        end
                        default: begin
                            cr_ff[7:0] <= WDATA;
                        end
                    endcase
                end
                if (cnt_done) begin
                    null_ff <= 1'b1; // [RULE14]
                    load_ff <= 1'b1;
                    if (m04) begin
                        run_ff <= 1'b0; // [RULE16] [RULE17]
                        if (!mode_ff[2]) begin
                            out_ff <= 1'b0; // [RULE15]
                        end
                    end
                end
            end
        end

        // Output latch, status latch and read byte sequencing.
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                ol_ff      <= pit_pkg::RST_COUNT;
                st_ff      <= 8'h00;
                ol_held_ff <= 1'b0;
                st_held_ff <= 1'b0;
                rd_hi_ff   <= 1'b0;
            end else if (my_cw) begin
                // Reprogramming releases any held value. [RULE9]
                ol_held_ff <= 1'b0;
                st_held_ff <= 1'b0;
                rd_hi_ff   <= 1'b0;
            end else begin
                if (lat_cnt && !ol_held_ff) begin
                    ol_ff      <= ce_ff; // [RULE9] [RULE10]
                    ol_held_ff <= 1'b1;
                end
                if (lat_st && !st_held_ff) begin
                    st_ff      <= status; // [RULE12] [RULE13]
                    st_held_ff <= 1'b1;
                end
                if (rd_hit) begin
                    if (st_held_ff) begin
                        st_held_ff <= 1'b0; // [RULE3]
                    end else begin
                        if (fmt_ff == pit_pkg::PIT_FMT_BOTH) begin
                            rd_hi_ff <= !rd_hi_ff;
                        end
                        if (fmt_ff != pit_pkg::PIT_FMT_BOTH || rd_hi_ff) begin
                            ol_held_ff <= 1'b0; // [RULE3] [RULE9]
                        end
                    end
                end
            end
        end

        // Unlatched reads see the live element, which may be moving.
        assign src = ol_held_ff ? ol_ff : ce_ff; // [RULE8]
        assign rd_byte[i] = st_held_ff ? st_ff : // [RULE3]
            ((fmt_ff == pit_pkg::PIT_FMT_MSB) ||
             ((fmt_ff == pit_pkg::PIT_FMT_BOTH) && rd_hi_ff)) ?
            src[15:8] : src[7:0];

        // Counter output pin comes straight from its flop.
        assign CNT_OUT[i] = out_ff;
    end

    // Read data stand for exactly one cycle after the read strobe.
    // The control location reads as zero, like an idle bus.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (RD_STB && ADDR < 2'(NUM_CNT)) begin
            RDATA <= rd_byte[ADDR];
        end else begin
            RDATA <= 8'h00;
        end
    end

endmodule

// ===== dv/pit_timer_props.sv
// Checker of the timer's output waveforms against bus writes and pins.
`timescale 1ns/1ps
module pit_timer_props #(
    parameter int NUM_CNT = 3
) (
    input wire logic               CLOCK,
    input wire logic               RST_N,
    input wire logic [1:0]         ADDR,
    input wire logic [7:0]         WDATA,
    input wire logic               WR_STB,
    input wire logic               RD_STB,
    input wire logic [7:0]         RDATA,
    input wire logic [NUM_CNT-1:0] CNT_CLK,
    input wire logic [NUM_CNT-1:0] CNT_GATE,
    input wire logic [NUM_CNT-1:0] CNT_OUT
);
    logic [2:0] mode_ff [3];
    logic [1:0] fmt_ff  [3];
    logic       hi_ff;
    logic       cw_wr;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    // A programming control word; latch and read-back commands excluded.
    assign cw_wr = WR_STB && ADDR == 2'h3 && WDATA[7:6] != 2'h3
                   && WDATA[5:4] != 2'h0;

    // Shadow of each counter's mode and byte format.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < 3; i++) begin
                mode_ff[i] <= 3'h0;
                fmt_ff[i]  <= 2'h1;
            end
        end else if (cw_wr) begin
            mode_ff[WDATA[7:6]] <= WDATA[3:1];
            fmt_ff[WDATA[7:6]]  <= WDATA[5:4];
        end
    end

    // Tracks which byte of a two-byte count counter 1 expects next.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            hi_ff <= 1'b0;
        end else if (cw_wr && WDATA[7:6] == 2'h1) begin
            hi_ff <= 1'b0;
        end else if (WR_STB && ADDR == 2'h1 && fmt_ff[1] == 2'h3) begin
            hi_ff <= !hi_ff;
        end
    end

    sequence s_cw(logic [1:0] sel, logic [2:0] md);
        cw_wr && WDATA[7:6] == sel && WDATA[3:1] == md;
    endsequence

    sequence s_first_byte;
        mode_ff[1] == 3'h0 && fmt_ff[1] == 2'h3 && !hi_ff && WR_STB
        && ADDR == 2'h1;
    endsequence

    a_m0_cw_low: assert property (
        s_cw(2'h0, 3'h0) |=> ##[0:2] !CNT_OUT[0])
        else $error("mode 0 control word left output high");
    a_m1_cw_high: assert property (
        s_cw(2'h2, 3'h1) |=> ##[0:2] CNT_OUT[2])
        else $error("mode 1 output not idle high");
    a_m2_cw_high: assert property (
        s_cw(2'h0, 3'h2) |=> ##[0:2] CNT_OUT[0])
        else $error("mode 2 output not idle high");
    a_first_byte_low: assert property (
        s_first_byte |=> ##[0:2] !CNT_OUT[1])
        else $error("first count byte did not lower output");
    a_gate_low_high: assert property (
        mode_ff[0] == 3'h2 && $fell(CNT_GATE[0]) |-> ##[1:4] CNT_OUT[0])
        else $error("gate low did not force output high");
    a_m0_rise_clk: assert property (
        mode_ff[0] == 3'h0 && $rose(CNT_OUT[0]) |-> $past(CNT_CLK[0], 2))
        else $error("mode 0 output rose without a count clock");
    a_m1_fall_clk: assert property (
        mode_ff[2] == 3'h1 && $fell(CNT_OUT[2]) |-> $past(CNT_CLK[2], 2))
        else $error("mode 1 output fell without a count clock");
    a_m2_fall_clk: assert property (
        mode_ff[0] == 3'h2 && $fell(CNT_OUT[0]) |-> $past(CNT_CLK[0], 2))
        else $error("mode 2 output fell without a count clock");
endmodule

bind pit_timer pit_timer_props #(.NUM_CNT(NUM_CNT)) u_props (
    .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
    .CNT_CLK(CNT_CLK), .CNT_GATE(CNT_GATE), .CNT_OUT(CNT_OUT));

// ===== dv/pit_host.sv
// Bus master model that programs and reads the timer.
`timescale 1ns/1ps
module pit_host (
    input  wire logic       CLOCK,
    output logic      [1:0] ADDR,
    output logic      [7:0] WDATA,
    output logic            WR_STB,
    output logic            RD_STB,
    input  wire logic [7:0] RDATA
);
    // Idle bus from time zero.
    initial begin
        ADDR   = 2'h0;
        WDATA  = 8'h00;
        WR_STB = 1'b0;
        RD_STB = 1'b0;
    end

    // Data is inverted after the strobe so stale values never match.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        ADDR   <= a;
        WDATA  <= d;
        WR_STB <= 1'b1;
        @(posedge CLOCK);
        WR_STB <= 1'b0;
        WDATA  <= ~d;
    endtask

    // Read data is taken in the single cycle where it stands.
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge CLOCK);
        ADDR   <= a;
        RD_STB <= 1'b1;
        @(posedge CLOCK);
        RD_STB <= 1'b0;
        @(posedge CLOCK);
        d = RDATA;
    endtask

    // Two-byte count, low byte first, nothing in between.
    task automatic wr16(input logic [1:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask

    // Two consecutive reads give one 16-bit value.
    task automatic rd16(input logic [1:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a, v[15:8]);
    endtask
endmodule

// ===== dv/interval_timer_program_readout_tb_top.sv
// Self-checking bench of the three-counter interval timer.
`timescale 1ns/1ps
module interval_timer_program_readout_tb_top;
    logic        clock;
    logic        rst_n;
    logic [1:0]  addr;
    logic [7:0]  wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  rdata;
    logic [2:0]  cnt_clk;
    logic [2:0]  cnt_gate;
    logic [2:0]  cnt_out;
    logic [15:0] v;
    logic [7:0]  b;
    int          n_errors;
    int          compares;

    pit_timer #(.NUM_CNT(3)) u_dut (
        .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
        .CNT_CLK(cnt_clk), .CNT_GATE(cnt_gate), .CNT_OUT(cnt_out));
    pit_host u_host (
        .CLOCK(clock), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .RDATA(rdata));

    // 200 MHz system clock.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Count clock pulses, slow enough for the two-flop synchroniser.
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge clock);
            cnt_clk[i] <= 1'b1;
            repeat (4) @(posedge clock);
            cnt_clk[i] <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask

    task automatic gate(input int i, input logic g);
        @(posedge clock);
        cnt_gate[i] <= g;
        repeat (4) @(posedge clock);
    endtask

    task automatic out_is(input int i, input logic e);
        @(posedge clock);
        check({15'h0, cnt_out[i]}, {15'h0, e});
    endtask

    task automatic rd_is(input logic [1:0] a, input logic [7:0] e);
        u_host.rd(a, b);
        check({8'h0, b}, {8'h0, e});
    endtask

    task automatic report_and_stop;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The tests need well under 3000 cycles; this cuts a hang short.
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end

    // Counters are programmed out of order to show they are separate.
    initial begin
        n_errors = 0;
        compares = 0;
        rst_n    = 1'b0;
        cnt_clk  = 3'h0;
        cnt_gate = 3'h3;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        u_host.wr(2'h3, 8'h70);
        u_host.wr16(2'h1, 16'h0002);
        u_host.wr(2'h3, 8'h10);
        out_is(0, 1'b0);
        u_host.wr(2'h3, 8'hd2);
        rd_is(2'h0, 8'h50);
        u_host.wr(2'h0, 8'h03);
        pulse(0, 1);
        rd_is(2'h0, 8'h03);
        u_host.wr(2'h3, 8'hd2);
        rd_is(2'h0, 8'h10);
        pulse(0, 2);
        out_is(0, 1'b0);
        pulse(0, 1);
        out_is(0, 1'b1);
        pulse(0, 1);
        rd_is(2'h0, 8'hff);
        $display("test mode0 count done");
        pulse(1, 3);
        out_is(1, 1'b1);
        u_host.wr(2'h1, 8'h05);
        out_is(1, 1'b0);
        pulse(1, 1);
        u_host.wr(2'h1, 8'h00);
        pulse(1, 1);
        u_host.wr(2'h3, 8'h40);
        pulse(1, 1);
        u_host.wr(2'h3, 8'h40);
        u_host.rd16(2'h1, v);
        check(v, 16'h0005);
        u_host.wr(2'h3, 8'h40);
        pulse(1, 1);
        u_host.wr(2'h3, 8'hd4);
        rd_is(2'h1, 8'h30);
        u_host.rd16(2'h1, v);
        check(v, 16'h0004);
        u_host.rd16(2'h1, v);
        check(v, 16'h0003);
        $display("test latch readback done");
        u_host.wr(2'h3, 8'h92);
        out_is(2, 1'b1);
        u_host.wr(2'h3, 8'hda);
        rd_is(2'h2, 8'hd2);
        rd_is(2'h0, 8'h90);
        u_host.wr(2'h2, 8'h02);
        gate(2, 1'b1);
        pulse(2, 1);
        out_is(2, 1'b0);
        u_host.wr(2'h2, 8'h05);
        pulse(2, 1);
        out_is(2, 1'b0);
        pulse(2, 1);
        out_is(2, 1'b1);
        gate(2, 1'b0);
        gate(2, 1'b1);
        pulse(2, 5);
        out_is(2, 1'b0);
        pulse(2, 1);
        out_is(2, 1'b1);
        $display("test mode1 one-shot done");
        u_host.wr(2'h3, 8'h14);
        out_is(0, 1'b1);
        u_host.wr(2'h0, 8'h03);
        pulse(0, 3);
        out_is(0, 1'b0);
        pulse(0, 1);
        out_is(0, 1'b1);
        pulse(0, 2);
        out_is(0, 1'b0);
        gate(0, 1'b0);
        out_is(0, 1'b1);
        gate(0, 1'b1);
        $display("test mode2 rate done");
        // High byte only; the low byte must read back cleared.
        u_host.wr(2'h3, 8'h20);
        u_host.wr(2'h0, 8'h01);
        pulse(0, 1);
        // Reformat to two bytes; the element keeps its value.
        u_host.wr(2'h3, 8'h30);
        u_host.wr(2'h3, 8'hf2);
        rd_is(2'h0, 8'h70);
        u_host.rd16(2'h0, v);
        check(v, 16'h0100);
        // Decimal mode 0, count written and loaded with the gate low.
        gate(0, 1'b0);
        u_host.wr(2'h3, 8'h31);
        u_host.wr16(2'h0, 16'h0002);
        pulse(0, 3);
        out_is(0, 1'b0);
        gate(0, 1'b1);
        pulse(0, 1);
        out_is(0, 1'b0);
        pulse(0, 1);
        out_is(0, 1'b1);
        pulse(0, 1);
        u_host.rd16(2'h0, v);
        check(v, 16'h9999);
        $display("test readback decimal done");
        report_and_stop();
    end
endmodule
